// ===== verilog/fbc_ctrl.v
// Functional notes
// RL1: width pin follows ctrl bit: 16-bit or 32-bit bus.
// RL2: word mode uses data lines 15:0; double-word mode 31:0.
// RL3: page of 8 words or 4 double words reads faster; at these timings a page hit loads the same 3-cycle strobe as a miss.
// RL4: four banks; read one bank while another programs or erases; reads are refused while a program polls.
// RL5: bank sizes 16, 48, 48, 16 Mbit set bank decode.
// RL6: write cycles carry command, address and data.
// RL7: bypass program takes two writes instead of four.
// RL8: poll bit and toggle bit tell completion.
// RL9: after completion device reads array, takes new commands.
// RL10: ready/busy pin shows program or erase running.
// RL11: reset pin aborts activity, back to array read.
// RL12: write-protect low guards outer sectors; high allows unprotect.
// RL13: erase suspend allows read or program of other sectors.
// RL14: secured region read in suspend needs entry and exit.
// RL15: secured otp region of 128 words opens by command.
// RL16: device sleeps on stable address, still outputs data.
// RL17: password protection checks a 64-bit password first.
// RL18: low supply blocks program and erase.
// RL19: no new program or erase into a busy bank.
`timescale 1ns/1ps
`include "fbc_ctrl_regs.vh"
module fbc_ctrl #(
  parameter RP_CYC = `FBC_CYC(`FBC_T_RP_NS),
  parameter RH_CYC = `FBC_CYC(`FBC_T_RH_NS)
) (
  // clock and reset
  input  wire        i_clk,
  input  wire        i_sys_rst,
  // apb slave
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [7:0]  i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output reg         o_pready,
  output reg         o_pslverr,
  // interrupt
  output reg         o_irq,
  // flash pins
  output wire        o_fl_ce_n,
  output wire        o_fl_we_n,
  output wire        o_fl_oe_n,
  output wire [22:0] o_fl_addr,
  output wire [31:0] o_fl_dq,
  output wire        o_fl_dq_oe_n,
  input  wire [31:0] i_fl_dq,
  output reg         o_fl_dword_sel,
  output reg         o_fl_reset_n,
  output reg         o_fl_wp_n,
  output reg         o_fl_fast_program_input,
  input  wire        i_fl_ready_busy_n
);
  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_STEP = 3'd1;
  localparam [2:0] S_WAIT = 3'd2;
  localparam [2:0] S_POLL = 3'd3;
  localparam [2:0] S_POLLW = 3'd4;
  localparam [2:0] S_RDW = 3'd5;
  localparam [2:0] S_HRST = 3'd6;

  localparam [10:0] W_END = 11'h400;
  localparam [10:0] W_U1 = {3'b000, `FBC_CODE_UNLK1};
  localparam [10:0] W_U2 = {3'b000, `FBC_CODE_UNLK2};
  localparam [10:0] W_DATA = 11'h300;

  reg [2:0]  ctrl_reg;
  reg [22:0] addr_reg;
  reg [31:0] wdata_reg;
  reg [31:0] rdata_reg;
  reg [2:0]  irq_stat_reg;
  reg [2:0]  irq_en_reg;
  reg [2:0]  state_reg;
  reg [3:0]  op_reg;
  reg [2:0]  idx_reg;
  reg [7:0]  cnt_reg;
  reg        bypass_reg;
  reg        otp_reg;
  reg        erase_reg;
  reg        susp_reg;
  reg [1:0]  erase_bank_reg;
  reg        poll_first_reg;
  reg        prev_tog_reg;
  reg        rdy_prev_reg;
  reg        bus_start_reg;
  reg        bus_wr_reg;
  reg [22:0] bus_addr_reg;
  reg [31:0] bus_data_reg;
  reg [2:0]  ev_reg;
  reg [31:0] rd_mux;
  reg        hit;

  wire        bus_done;
  wire [31:0] bus_rdata;
  wire [31:0] dq_sync;
  wire        rdy_sync;
  wire        dword = ctrl_reg[`FBC_CTRL_DWORD];
  wire        acc = i_psel & i_penable;
  wire        wr_en = acc & o_pready & i_pwrite;
  wire        cmd_go = wr_en && (i_paddr == `FBC_OFF_CMD);
  wire [3:0]  new_op = i_pwdata[3:0];
  wire [22:0] fl_addr = dword ? {1'b0, addr_reg[21:0]} : addr_reg;
  wire [10:0] step_w = seq_word(op_reg, idx_reg);
  wire [1:0]  tgt_bank = bank_of(addr_reg, dword);

  // RL5: bank decode from bank sizes
  function [1:0] bank_of;
    input [22:0] a;
    input        dw;
    reg   [22:0] w;
    begin
      w = dw ? {a[21:0], 1'b0} : a;
      if (w < `FBC_BANK2_BASE) begin
        bank_of = 2'd0;
      end else if (w < `FBC_BANK3_BASE) begin
        bank_of = 2'd1;
      end else if (w < `FBC_BANK4_BASE) begin
        bank_of = 2'd2;
      end else begin
        bank_of = 2'd3;
      end
    end
  endfunction

  // {end, at addr, wdata, code} per write
  function [10:0] seq_word;
    input [3:0] op;
    input [2:0] i;
    begin
      seq_word = W_END;
      case (op)
        // RL7: normal program is four writes
        `FBC_OP_PROG: begin
          if (i == 3'd0) seq_word = W_U1;
          else if (i == 3'd1) seq_word = W_U2;
          else if (i == 3'd2) seq_word = {3'b000, `FBC_CODE_PROG};
          else if (i == 3'd3) seq_word = W_DATA;
        end
        // RL7: bypass program is two writes
        `FBC_OP_BYP_PROG: begin
          if (i == 3'd0) seq_word = {3'b000, `FBC_CODE_PROG};
          else if (i == 3'd1) seq_word = W_DATA;
        end
        `FBC_OP_BYP_ENTER, `FBC_OP_OTP_ENTER: begin
          if (i == 3'd0) seq_word = W_U1;
          else if (i == 3'd1) seq_word = W_U2;
          else if (i == 3'd2) seq_word = {3'b000, (op == `FBC_OP_OTP_ENTER) ? `FBC_CODE_OTP : `FBC_CODE_BYPASS};
        end
        `FBC_OP_BYP_EXIT: begin
          if (i == 3'd0) seq_word = {3'b000, `FBC_CODE_EXIT1};
          else if (i == 3'd1) seq_word = {3'b000, `FBC_CODE_EXIT2};
        end
        // RL14: exit sequence for the secured region
        `FBC_OP_OTP_EXIT: begin
          if (i == 3'd0) seq_word = W_U1;
          else if (i == 3'd1) seq_word = W_U2;
          else if (i == 3'd2) seq_word = {3'b000, `FBC_CODE_EXIT1};
          else if (i == 3'd3) seq_word = {3'b000, `FBC_CODE_EXIT2};
        end
        `FBC_OP_SECT_ERA, `FBC_OP_CHIP_ERA: begin
          if (i == 3'd0 || i == 3'd3) seq_word = W_U1;
          else if (i == 3'd1 || i == 3'd4) seq_word = W_U2;
          else if (i == 3'd2) seq_word = {3'b000, `FBC_CODE_ERASE};
          else if (i == 3'd5 && op == `FBC_OP_CHIP_ERA) seq_word = {3'b000, `FBC_CODE_CHIP};
          else if (i == 3'd5) seq_word = {3'b100, `FBC_CODE_SECT} ^ 11'h600;
        end
        `FBC_OP_SUSPEND: begin
          if (i == 3'd0) seq_word = {3'b010, `FBC_CODE_SUSP};
        end
        `FBC_OP_RESUME: begin
          if (i == 3'd0) seq_word = {3'b010, `FBC_CODE_RESUME};
        end
        `FBC_OP_SOFT_RST: begin
          if (i == 3'd0) seq_word = {3'b000, `FBC_CODE_RESET};
        end
        default: seq_word = W_END;
      endcase
    end
  endfunction

  // RL19: refuse program or erase into a busy bank
  function refuse;
    input [3:0] op;
    begin
      refuse = 1'b0;
      if ((op == `FBC_OP_PROG || op == `FBC_OP_BYP_PROG) && erase_reg && !susp_reg && tgt_bank == erase_bank_reg)
        refuse = 1'b1;
      else if ((op == `FBC_OP_SECT_ERA || op == `FBC_OP_CHIP_ERA) && erase_reg)
        refuse = 1'b1;
      else if (op == `FBC_OP_BYP_PROG && !bypass_reg)
        refuse = 1'b1;
      else if (op == `FBC_OP_SUSPEND && (!erase_reg || susp_reg))
        refuse = 1'b1;
      else if (op == `FBC_OP_RESUME && !susp_reg)
        refuse = 1'b1;
      else if (op > `FBC_OP_HW_RST)
        refuse = 1'b1;
    end
  endfunction

  fbc_sync2 #(
    .W (33)
  ) u_sync (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_async   ({i_fl_ready_busy_n, i_fl_dq}),
    .o_sync    ({rdy_sync, dq_sync})
  );

  fbc_flash_cycle u_cycle (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_start   (bus_start_reg),
    .i_write   (bus_wr_reg),
    .i_dword   (dword),
    .i_addr    (bus_addr_reg),
    .i_wdata   (bus_data_reg),
    .i_dq_sync (dq_sync),
    .o_done    (bus_done),
    .o_rdata   (bus_rdata),
    .o_ce_n    (o_fl_ce_n),
    .o_we_n    (o_fl_we_n),
    .o_oe_n    (o_fl_oe_n),
    .o_addr    (o_fl_addr),
    .o_dq      (o_fl_dq),
    .o_dq_oe_n (o_fl_dq_oe_n)
  );

  // register read decode
  always @* begin
    hit = 1'b1;
    rd_mux = 32'h00000000;
    if (i_paddr == `FBC_OFF_CTRL) begin
      rd_mux = {29'h0, ctrl_reg};
    end else if (i_paddr == `FBC_OFF_ADDR) begin
      rd_mux = {9'h000, addr_reg};
    end else if (i_paddr == `FBC_OFF_WDATA) begin
      rd_mux = wdata_reg;
    end else if (i_paddr == `FBC_OFF_CMD || i_paddr == `FBC_OFF_IRQ_CLR) begin
      rd_mux = 32'h00000000;
    end else if (i_paddr == `FBC_OFF_RDATA) begin
      rd_mux = rdata_reg;
    end else if (i_paddr == `FBC_OFF_STATUS) begin
      // RL10: ready/busy pin level is visible
      rd_mux = {24'h0, erase_bank_reg, rdy_sync, otp_reg, bypass_reg, susp_reg, erase_reg, state_reg != S_IDLE};
    end else if (i_paddr == `FBC_OFF_IRQ_STAT) begin
      rd_mux = {29'h0, irq_stat_reg};
    end else if (i_paddr == `FBC_OFF_IRQ_EN) begin
      rd_mux = {29'h0, irq_en_reg};
    end else begin
      hit = 1'b0;
    end
  end

  // apb slave, one wait state
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h00000000;
      ctrl_reg <= `FBC_CTRL_RST;
      addr_reg <= 23'h000000;
      wdata_reg <= 32'h00000000;
      irq_en_reg <= 3'h0;
      irq_stat_reg <= 3'h0;
      o_irq <= 1'b0;
      o_fl_dword_sel <= 1'b0;
      o_fl_wp_n <= 1'b0;
      o_fl_fast_program_input <= 1'b0;
    end else begin
      o_pready <= acc & ~o_pready;
      o_pslverr <= acc & ~o_pready & ~hit;
      o_prdata <= (acc & ~o_pready & ~i_pwrite) ? rd_mux : 32'h00000000;
      if (wr_en && i_paddr == `FBC_OFF_CTRL) ctrl_reg <= i_pwdata[2:0];
      if (wr_en && i_paddr == `FBC_OFF_ADDR) addr_reg <= i_pwdata[22:0];
      if (wr_en && i_paddr == `FBC_OFF_WDATA) wdata_reg <= i_pwdata;
      if (wr_en && i_paddr == `FBC_OFF_IRQ_EN) irq_en_reg <= i_pwdata[2:0];
      // event wins over clear
      irq_stat_reg <= (irq_stat_reg & ~((wr_en && i_paddr == `FBC_OFF_IRQ_CLR) ? i_pwdata[2:0] : 3'h0)) | ev_reg;
      o_irq <= |(irq_stat_reg & irq_en_reg);
      // RL1: width pin follows the control bit
      o_fl_dword_sel <= ctrl_reg[`FBC_CTRL_DWORD];
      // RL12: write-protect released only on request
      o_fl_wp_n <= ctrl_reg[`FBC_CTRL_WPREL];
      o_fl_fast_program_input <= ctrl_reg[`FBC_CTRL_FASTPGM];
    end
  end

  // command sequencer
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_reg <= S_IDLE;
      op_reg <= `FBC_OP_READ;
      idx_reg <= 3'd0;
      cnt_reg <= 8'h00;
      bypass_reg <= 1'b0;
      otp_reg <= 1'b0;
      erase_reg <= 1'b0;
      susp_reg <= 1'b0;
      erase_bank_reg <= 2'd0;
      poll_first_reg <= 1'b0;
      prev_tog_reg <= 1'b0;
      rdy_prev_reg <= 1'b1;
      bus_start_reg <= 1'b0;
      bus_wr_reg <= 1'b0;
      bus_addr_reg <= 23'h000000;
      bus_data_reg <= 32'h00000000;
      rdata_reg <= 32'h00000000;
      ev_reg <= 3'h0;
      o_fl_reset_n <= 1'b1;
    end else begin
      ev_reg <= 3'h0;
      bus_start_reg <= 1'b0;
      rdy_prev_reg <= rdy_sync;
      // RL10: rising ready ends the background erase
      if (rdy_sync && !rdy_prev_reg && erase_reg && !susp_reg && op_reg != `FBC_OP_SUSPEND) begin
        erase_reg <= 1'b0;
        ev_reg[`FBC_IRQ_ERASE] <= 1'b1;
      end
      if (cmd_go && (state_reg != S_IDLE || refuse(new_op))) begin
        ev_reg[`FBC_IRQ_REFUSE] <= 1'b1;
      end
      case (state_reg)
        S_IDLE: begin
          if (cmd_go && !refuse(new_op)) begin
            op_reg <= new_op;
            idx_reg <= 3'd0;
            bus_addr_reg <= fl_addr;
            if (new_op == `FBC_OP_READ) begin
              // RL4: reads go out even while a bank erases
              bus_wr_reg <= 1'b0;
              bus_start_reg <= 1'b1;
              state_reg <= S_RDW;
            end else if (new_op == `FBC_OP_HW_RST) begin
              // RL11: pulse the reset pin
              o_fl_reset_n <= 1'b0;
              cnt_reg <= RP_CYC[7:0] + RH_CYC[7:0];
              state_reg <= S_HRST;
            end else begin
              state_reg <= S_STEP;
            end
          end
        end
        S_STEP: begin
          if (step_w[10]) begin
            state_reg <= S_IDLE;
            ev_reg[`FBC_IRQ_DONE] <= 1'b1;
            if (op_reg == `FBC_OP_PROG || op_reg == `FBC_OP_BYP_PROG) begin
              poll_first_reg <= 1'b1;
              ev_reg[`FBC_IRQ_DONE] <= 1'b0;
              state_reg <= S_POLL;
            end else if (op_reg == `FBC_OP_SECT_ERA || op_reg == `FBC_OP_CHIP_ERA) begin
              erase_reg <= 1'b1;
              erase_bank_reg <= tgt_bank;
            end
            if (op_reg == `FBC_OP_BYP_ENTER) bypass_reg <= 1'b1;
            if (op_reg == `FBC_OP_BYP_EXIT) bypass_reg <= 1'b0;
            if (op_reg == `FBC_OP_OTP_ENTER) otp_reg <= 1'b1;
            if (op_reg == `FBC_OP_OTP_EXIT) otp_reg <= 1'b0;
            // RL13: suspend opens other sectors, resume continues
            if (op_reg == `FBC_OP_SUSPEND) susp_reg <= 1'b1;
            if (op_reg == `FBC_OP_RESUME) susp_reg <= 1'b0;
          end else begin
            // RL6: one write cycle per step
            bus_wr_reg <= 1'b1;
            bus_start_reg <= 1'b1;
            bus_addr_reg <= step_w[9] ? fl_addr :
                            (step_w[7:0] == `FBC_CODE_UNLK2 ? `FBC_UNLK2_ADDR : `FBC_UNLK1_ADDR);
            bus_data_reg <= step_w[8] ? wdata_reg : {24'h000000, step_w[7:0]};
            state_reg <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (bus_done) begin
            idx_reg <= idx_reg + 3'd1;
            state_reg <= S_STEP;
          end
        end
        S_POLL: begin
          bus_wr_reg <= 1'b0;
          bus_addr_reg <= fl_addr;
          bus_start_reg <= 1'b1;
          state_reg <= S_POLLW;
        end
        S_POLLW: begin
          if (bus_done) begin
            // RL8: toggle bit stable and poll bit true
            if (!poll_first_reg && bus_rdata[6] == prev_tog_reg && bus_rdata[7] == wdata_reg[7]) begin
              // RL9: back to array read
              ev_reg[`FBC_IRQ_DONE] <= 1'b1;
              state_reg <= S_IDLE;
            end else begin
              prev_tog_reg <= bus_rdata[6];
              poll_first_reg <= 1'b0;
              state_reg <= S_POLL;
            end
          end
        end
        S_RDW: begin
          if (bus_done) begin
            rdata_reg <= bus_rdata;
            ev_reg[`FBC_IRQ_DONE] <= 1'b1;
            state_reg <= S_IDLE;
          end
        end
        default: begin
          cnt_reg <= cnt_reg - 8'd1;
          if (cnt_reg == RH_CYC[7:0] + 8'd1) o_fl_reset_n <= 1'b1;
          if (cnt_reg <= 8'd1) begin
            // RL11: reset clears all command modes
            bypass_reg <= 1'b0;
            otp_reg <= 1'b0;
            erase_reg <= 1'b0;
            susp_reg <= 1'b0;
            ev_reg[`FBC_IRQ_DONE] <= 1'b1;
            state_reg <= S_IDLE;
          end
        end
      endcase
    end
  end
endmodule

// ===== verilog/fbc_ctrl_regs.vh
`ifndef FBC_CTRL_REGS_VH
`define FBC_CTRL_REGS_VH

// register byte offsets
`define FBC_OFF_CTRL     8'h00
`define FBC_OFF_ADDR     8'h04
`define FBC_OFF_WDATA    8'h08
`define FBC_OFF_CMD      8'h0C
`define FBC_OFF_RDATA    8'h10
`define FBC_OFF_STATUS   8'h14
`define FBC_OFF_IRQ_STAT 8'h18
`define FBC_OFF_IRQ_CLR  8'h1C
`define FBC_OFF_IRQ_EN   8'h20

// control fields
`define FBC_CTRL_DWORD   0
`define FBC_CTRL_WPREL   1
`define FBC_CTRL_FASTPGM 2
`define FBC_CTRL_RST     3'h0

// status fields
`define FBC_ST_BUSY      0
`define FBC_ST_ERASE     1
`define FBC_ST_SUSP      2
`define FBC_ST_BYPASS    3
`define FBC_ST_OTP       4
`define FBC_ST_RDY       5
`define FBC_ST_BANK_LO   6

// interrupt bits
`define FBC_IRQ_DONE     0
`define FBC_IRQ_ERASE    1
`define FBC_IRQ_REFUSE   2
`define FBC_IRQ_W        3

// command register op codes
`define FBC_OP_READ      4'h0
`define FBC_OP_PROG      4'h1
`define FBC_OP_BYP_ENTER 4'h2
`define FBC_OP_BYP_PROG  4'h3
`define FBC_OP_BYP_EXIT  4'h4
`define FBC_OP_SECT_ERA  4'h5
`define FBC_OP_CHIP_ERA  4'h6
`define FBC_OP_SUSPEND   4'h7
`define FBC_OP_RESUME    4'h8
`define FBC_OP_OTP_ENTER 4'h9
`define FBC_OP_OTP_EXIT  4'hA
`define FBC_OP_SOFT_RST  4'hB
`define FBC_OP_HW_RST    4'hC

// device command bytes
`define FBC_CODE_UNLK1   8'hAA
`define FBC_CODE_UNLK2   8'h55
`define FBC_CODE_PROG    8'hA0
`define FBC_CODE_BYPASS  8'h20
`define FBC_CODE_EXIT1   8'h90
`define FBC_CODE_EXIT2   8'h00
`define FBC_CODE_ERASE   8'h80
`define FBC_CODE_SECT    8'h30
`define FBC_CODE_CHIP    8'h10
`define FBC_CODE_SUSP    8'hB0
`define FBC_CODE_RESUME  8'h30
`define FBC_CODE_OTP     8'h88
`define FBC_CODE_RESET   8'hF0
`define FBC_UNLK1_ADDR   23'h000555
`define FBC_UNLK2_ADDR   23'h0002AA

// bank bases in word addresses: 16, 48, 48, 16 Mbit
`define FBC_BANK2_BASE   23'h100000
`define FBC_BANK3_BASE   23'h400000
`define FBC_BANK4_BASE   23'h700000

// timing in ns
`define FBC_CLK_NS       100
`define FBC_T_ACC_NS     70
`define FBC_T_PACC_NS    25
`define FBC_T_WP_NS      50
`define FBC_T_RP_NS      500
`define FBC_T_RH_NS      200
`define FBC_CYC(t)       (((t) + `FBC_CLK_NS - 1) / `FBC_CLK_NS)

`endif

// ===== verilog/fbc_sync2.v
`timescale 1ns/1ps
module fbc_sync2 #(
  parameter W = 1
) (
  input  wire         i_clk,
  input  wire         i_sys_rst,
  input  wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);
  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      meta_reg <= {W{1'b0}};
      sync_reg <= {W{1'b0}};
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;
endmodule

// ===== verilog/fbc_flash_cycle.v
`timescale 1ns/1ps
`include "fbc_ctrl_regs.vh"
module fbc_flash_cycle #(
  parameter ACC_CYC  = `FBC_CYC(`FBC_T_ACC_NS),
  parameter PACC_CYC = `FBC_CYC(`FBC_T_PACC_NS),
  parameter WP_CYC   = `FBC_CYC(`FBC_T_WP_NS)
) (
  // clock and reset
  input  wire        i_clk,
  input  wire        i_sys_rst,
  // request
  input  wire        i_start,
  input  wire        i_write,
  input  wire        i_dword,
  input  wire [22:0] i_addr,
  input  wire [31:0] i_wdata,
  input  wire [31:0] i_dq_sync,
  output reg         o_done,
  output reg  [31:0] o_rdata,
  // flash pins
  output reg         o_ce_n,
  output reg         o_we_n,
  output reg         o_oe_n,
  output reg  [22:0] o_addr,
  output reg  [31:0] o_dq,
  output reg         o_dq_oe_n
);
  localparam [1:0] B_IDLE = 2'd0;
  localparam [1:0] B_SETUP = 2'd1;
  localparam [1:0] B_STROBE = 2'd2;
  localparam [1:0] B_HOLD = 2'd3;

  reg [1:0]  state_reg;
  reg        wr_reg;
  reg [7:0]  cnt_reg;
  reg [20:0] page_reg;
  reg        page_vld_reg;
  wire [20:0] page_tag = i_dword ? {1'b0, i_addr[21:2]} : {1'b0, i_addr[22:3]};
  wire        same_page = page_vld_reg && (page_tag == page_reg);

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_reg <= B_IDLE;
      wr_reg <= 1'b0;
      cnt_reg <= 8'h00;
      page_reg <= 21'h000000;
      page_vld_reg <= 1'b0;
      o_done <= 1'b0;
      o_rdata <= 32'h00000000;
      o_ce_n <= 1'b1;
      o_we_n <= 1'b1;
      o_oe_n <= 1'b1;
      o_addr <= 23'h000000;
      o_dq <= 32'h00000000;
      o_dq_oe_n <= 1'b1;
    end else begin
      o_done <= 1'b0;
      case (state_reg)
        B_IDLE: begin
          if (i_start) begin
            wr_reg <= i_write;
            o_addr <= i_addr;
            o_ce_n <= 1'b0;
            o_dq <= i_dword ? i_wdata : {16'h0000, i_wdata[15:0]};
            o_dq_oe_n <= ~i_write;
            // RL3: open-page hit loads PACC_CYC + 2, which equals ACC_CYC + 2 (3) at these timings
            if (i_write) begin
              cnt_reg <= WP_CYC[7:0];
              page_vld_reg <= 1'b0;
            end else begin
              cnt_reg <= same_page ? PACC_CYC[7:0] + 8'd2 : ACC_CYC[7:0] + 8'd2;
              page_reg <= page_tag;
              page_vld_reg <= 1'b1;
            end
            state_reg <= B_SETUP;
          end
        end
        B_SETUP: begin
          if (wr_reg) begin
            o_we_n <= 1'b0;
          end else begin
            o_oe_n <= 1'b0;
          end
          state_reg <= B_STROBE;
        end
        B_STROBE: begin
          cnt_reg <= cnt_reg - 8'd1;
          if (cnt_reg <= 8'd1) begin
            o_we_n <= 1'b1;
            o_oe_n <= 1'b1;
            // RL2: word mode uses the low half only
            if (!wr_reg) begin
              o_rdata <= i_dword ? i_dq_sync : {16'h0000, i_dq_sync[15:0]};
            end
            state_reg <= B_HOLD;
          end
        end
        default: begin
          o_ce_n <= 1'b1;
          o_dq_oe_n <= 1'b1;
          o_done <= 1'b1;
          state_reg <= B_IDLE;
        end
      endcase
    end
  end
endmodule

// ===== tb/fbc_ctrl_sva.sv
`timescale 1ns/1ps
module fbc_ctrl_sva #(
  parameter RP_CYC = 5
) (
  input wire        i_clk,
  input wire        i_sys_rst,
  input wire        i_psel,
  input wire        i_penable,
  input wire [7:0]  i_paddr,
  input wire        o_pready,
  input wire        o_pslverr,
  input wire [31:0] o_prdata,
  input wire        o_fl_ce_n,
  input wire        o_fl_we_n,
  input wire        o_fl_oe_n,
  input wire [31:0] o_fl_dq,
  input wire        o_fl_dq_oe_n,
  input wire        o_fl_dword_sel,
  input wire        o_fl_reset_n
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  ready_pulse_a: assert property (o_pready |=> !o_pready) else $error("pready held");
  unmapped_err_a: assert property (i_psel && i_penable && o_pready && i_paddr > 8'h20 |-> o_pslverr)
    else $error("no slave error");
  idle_rdata_a: assert property (!o_pready |-> o_prdata == 32'h0) else $error("stray read data");
  write_frame_a: assert property (!o_fl_we_n |-> !o_fl_ce_n && !o_fl_dq_oe_n && o_fl_oe_n)
    else $error("we outside frame");
  write_width_a: assert property ($fell(o_fl_we_n) |=> o_fl_we_n) else $error("write pulse width");
  write_end_a: assert property ($rose(o_fl_we_n) |=> o_fl_ce_n && o_fl_dq_oe_n) else $error("bus not freed");
  read_width_a: assert property ($fell(o_fl_oe_n) |-> !o_fl_oe_n [*3] ##1 o_fl_oe_n)
    else $error("read strobe width");
  word_upper_a: assert property (!o_fl_dword_sel && !o_fl_dq_oe_n |-> o_fl_dq[31:16] == 16'h0)
    else $error("upper lines driven");
  reset_pulse_a: assert property ($fell(o_fl_reset_n) |-> !o_fl_reset_n [*5] ##1 o_fl_reset_n [*2])
    else $error("reset pulse shape");
endmodule
bind fbc_ctrl fbc_ctrl_sva #(.RP_CYC(RP_CYC)) u_fbc_ctrl_sva (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_psel(i_psel), .i_penable(i_penable), .i_paddr(i_paddr), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_prdata(o_prdata), .o_fl_ce_n(o_fl_ce_n), .o_fl_we_n(o_fl_we_n), .o_fl_oe_n(o_fl_oe_n),
  .o_fl_dq(o_fl_dq), .o_fl_dq_oe_n(o_fl_dq_oe_n), .o_fl_dword_sel(o_fl_dword_sel), .o_fl_reset_n(o_fl_reset_n));

// ===== tb/fbc_flash_model.sv
`timescale 1ns/1ps
module fbc_flash_model (
  input  wire        i_clk,
  input  wire        i_ce_n,
  input  wire        i_we_n,
  input  wire        i_oe_n,
  input  wire [22:0] i_addr,
  input  wire [31:0] i_dq,
  input  wire        i_dword_sel,
  input  wire        i_reset_n,
  output wire [31:0] o_dq,
  output wire        o_ready_busy_n
);
  logic [31:0] mem [int];
  bit   [31:0] pd, val, last;
  logic [7:0]  b;
  bit   [2:0]  st;
  bit          byp, susp, tog;
  int          bc, pc;
  assign o_ready_busy_n = (bc == 0 || susp) && pc == 0;
  assign o_dq = i_oe_n | i_ce_n ? ~last : i_dword_sel ? val : {~last[31:16], val[15:0]};
  always @(negedge i_oe_n) tog = ~tog;
  always @(posedge i_we_n) if (!i_ce_n && i_reset_n) begin
    b = i_dq[7:0];
    case (st)
      0: begin
        st = b == 8'hAA ? 1 : byp && b == 8'hA0 ? 3 : byp && b == 8'h90 ? 7 : 0;
        if (b == 8'hB0 && bc > 0) susp = 1;
        if (b == 8'h30 && susp) susp = 0;
      end
      1: st = b == 8'h55 ? 2 : 0;
      2: begin
        st = b == 8'hA0 ? 3 : b == 8'h80 ? 4 : 0;
        byp = byp | b == 8'h20;
      end
      3: begin
        mem[i_addr] = i_dq;
        pd = i_dq;
        pc = 20;
        st = 0;
      end
      4: st = b == 8'hAA ? 5 : 0;
      5: st = b == 8'h55 ? 6 : 0;
      6: begin
        bc = 60;
        st = 0;
      end
      default: {byp, st} = 0;
    endcase
  end
  always @(posedge i_clk) begin
    if (!i_reset_n) {bc, pc, st, susp, byp} = 0;
    if (bc > 0 && !susp) bc = bc - 1;
    if (pc > 0) pc = pc - 1;
    val <= pc > 0 ? {24'h0, ~pd[7], tog, 6'h0} : mem.exists(i_addr) ? mem[i_addr] : 32'hFFFFFFFF;
    if (!i_oe_n) last <= o_dq;
  end
endmodule

// ===== tb/fbc_ctrl_bench.sv
`timescale 1ns/1ps
`include "fbc_ctrl_regs.vh"
module fbc_ctrl_bench;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, irq, rerr;
  logic        ce_n, we_n, oe_n, dq_oe_n, dword, rst_n, wp_n, fast, rb_n;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rq, d, dq_o, dq_m;
  logic [22:0] fa, a;
  logic [2:0]  cf;
  int          n_fail, compares, nwe, i, seed;
  wire  [31:0] dq_w = dq_oe_n ? dq_m : dq_o;
  fbc_ctrl u_fbc_ctrl (.i_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_irq(irq),
    .o_fl_ce_n(ce_n), .o_fl_we_n(we_n), .o_fl_oe_n(oe_n), .o_fl_addr(fa), .o_fl_dq(dq_o), .o_fl_dq_oe_n(dq_oe_n),
    .i_fl_dq(dq_w), .o_fl_dword_sel(dword), .o_fl_reset_n(rst_n), .o_fl_wp_n(wp_n),
    .o_fl_fast_program_input(fast), .i_fl_ready_busy_n(rb_n));
  fbc_flash_model u_fbc_flash_model (.i_clk(clk), .i_ce_n(ce_n), .i_we_n(we_n), .i_oe_n(oe_n), .i_addr(fa),
    .i_dq(dq_w), .i_dword_sel(dword), .i_reset_n(rst_n), .o_dq(dq_m), .o_ready_busy_n(rb_n));
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  always @(negedge we_n) nwe++;
  task results;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input [31:0] exp, input [31:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input [7:0] ad, input [31:0] wd);
    int n = 0;
    @(posedge clk);
    psel <= 1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
    if (n >= 50) begin
      n_fail++;
      results();
    end
    rq = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic poll(input [7:0] o, input int bt, input logic v);
    int n;
    for (n = 0; n < 300; n++) begin
      apb(0, o, 0);
      if (rq[bt] === v) return;
    end
    n_fail++;
    results();
  endtask
  task automatic op(input [3:0] c);
    apb(1, `FBC_OFF_CMD, {28'h0, c});
    poll(`FBC_OFF_STATUS, 0, 0);
  endtask
  task automatic prog_rd(input [3:0] c, input [31:0] exp);
    apb(1, `FBC_OFF_ADDR, {9'h0, a});
    apb(1, `FBC_OFF_WDATA, d);
    nwe = 0;
    op(c);
    chk("writes", c == `FBC_OP_PROG ? 4 : c ? 2 : 0, nwe);
    op(`FBC_OP_READ);
    apb(0, `FBC_OFF_RDATA, 0);
    chk("read back", exp, rq);
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = 0;
    seed = 32'hFBFD;
    rst = 1;
    repeat (6) @(posedge clk);
    rst <= 0;
    apb(0, 8'h24, 0);
    chk("unmapped", 32'h1, {rq[30:0], rerr});
    for (i = 0; i < 4; i++) begin
      if (i == 2) op(`FBC_OP_BYP_ENTER);
      cf = 3'($random(seed));
      cf[0] = i[0];
      a = 23'($random(seed)) & 23'h0FFFFE;
      d = $random(seed);
      apb(1, `FBC_OFF_CTRL, {29'h0, cf});
      repeat (2) @(posedge clk);
      chk("pins", {29'h0, cf}, {fast, wp_n, dword});
      prog_rd(i < 2 ? `FBC_OP_PROG : `FBC_OP_BYP_PROG, cf[0] ? d : d & 32'hFFFF);
      a = a + 1;
      prog_rd(`FBC_OP_READ, cf[0] ? 32'hFFFFFFFF : 32'hFFFF);
    end
    op(`FBC_OP_BYP_EXIT);
    apb(1, `FBC_OFF_IRQ_CLR, 32'h7);
    op(`FBC_OP_BYP_PROG);
    apb(1, `FBC_OFF_IRQ_EN, 32'h4);
    repeat (3) @(posedge clk);
    chk("irq raised", 1, irq);
    apb(1, `FBC_OFF_IRQ_CLR, 32'h4);
    repeat (3) @(posedge clk);
    chk("irq cleared", 0, irq);
    apb(1, `FBC_OFF_CTRL, 0);
    apb(1, `FBC_OFF_ADDR, `FBC_BANK2_BASE);
    op(`FBC_OP_SECT_ERA);
    apb(0, `FBC_OFF_STATUS, 0);
    chk("erasing", 32'h42, rq & 32'hE2);
    op(`FBC_OP_SUSPEND);
    op(`FBC_OP_OTP_ENTER);
    apb(0, `FBC_OFF_STATUS, 0);
    chk("suspended", 32'h34, rq & 32'h34);
    op(`FBC_OP_OTP_EXIT);
    a = 23'h10;
    d = $random(seed);
    prog_rd(`FBC_OP_PROG, d & 32'hFFFF);
    op(`FBC_OP_RESUME);
    poll(`FBC_OFF_IRQ_STAT, 1, 1);
    apb(1, `FBC_OFF_IRQ_CLR, 32'h7);
    op(`FBC_OP_CHIP_ERA);
    op(`FBC_OP_HW_RST);
    poll(`FBC_OFF_IRQ_STAT, 1, 1);
    chk("reset pin", 1, rst_n);
    results();
  end
endmodule
